// ===== verilog/lcc_pkg.sv
// Package with constants, register map and carrier types for the logic cell cluster.
package lcc_pkg;

  // Number of logic cells in one cluster.
  localparam int unsigned CELL_COUNT = 8;
  // Number of LUT inputs per cell and resulting table depth.
  localparam int unsigned LUT_INPUTS = 4;
  localparam int unsigned LUT_DEPTH = 16;
  // Number of global net buffers feeding the cluster.
  localparam int unsigned GLOBAL_NET_BUFFER_COUNT = 8;

  // Register bus widths.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Byte offsets of the registers.
  localparam logic [7:0] OFS_LUT_BASE = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h20;
  localparam logic [7:0] OFS_SELECT = 8'h24;
  localparam logic [7:0] OFS_OUTSEL = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;

  // Field positions inside the output select register.
  localparam int unsigned POS_OUT_REG = 0;
  localparam int unsigned POS_SET_VAL = 8;
  // Field positions inside the status register.
  localparam int unsigned POS_ST_Q = 0;
  localparam int unsigned POS_ST_OUT = 8;
  localparam int unsigned POS_ST_CARRY = 16;
  localparam int unsigned POS_ST_GRST = 17;

  // Selector values that pick the general routing instead of a global buffer.
  localparam logic [3:0] CLK_SEL_ROUTE = 4'h8;
  localparam logic [2:0] CTL_SEL_ROUTE = 3'h4;

  // Cycles of global reset held after configuration completes.
  localparam logic [1:0] GRST_CYCLES = 2'h2;

  // Values after reset.
  localparam logic [15:0] RST_LUT = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // Control bits of the cluster.
  typedef struct packed {
    logic sr_use;
    logic ce_use;
    logic sr_async;
    logic cfg_done;
  } lcc_ctrl_type;

  // Source selectors of clock, clock enable and set/reset.
  typedef struct packed {
    logic [2:0] sr_sel;
    logic [2:0] ce_sel;
    logic [3:0] clk_sel;
  } lcc_sel_type;

  // Value of the control register after reset.
  localparam lcc_ctrl_type RST_CTRL = '{sr_use: 1'b0, ce_use: 1'b0, sr_async: 1'b0, cfg_done: 1'b0};
  // Value of the select register after reset.
  localparam lcc_sel_type RST_SEL = '{sr_sel: 3'h0, ce_sel: 3'h0, clk_sel: 4'h0};

endpackage

// ===== verilog/lcc_logic_cell_cluster.sv
// Logic block cluster of eight LUT and flip-flop cells with a shared control set.
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps

module lcc_logic_cell_cluster (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] global_net_buffer_in,
  input wire logic route_clk_in,
  input wire logic route_ce_in,
  input wire logic route_sr_in,
  input wire logic [7:0][3:0] lut_data_in,
  input wire logic fast_carry_in,
  output logic fast_carry_out,
  output logic [7:0] cell_out_out,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out
);

  // Reads one entry of a sixteen-entry table.
  function automatic logic lut_eval(input logic [15:0] table_bits, input logic [3:0] index);
    lut_eval = table_bits[index];
  endfunction

  // Majority of three bits, the carry of a full adder.
  function automatic logic majority(input logic a, input logic b, input logic c);
    majority = (a & b) | (a & c) | (b & c);
  endfunction

  // Picks a control source: buffer 2k or 2k+1 by parity, or routing.
  function automatic logic pick_ctl(input logic [7:0] bufs, input logic route, input logic [2:0] sel,
                                    input logic odd);
    logic [2:0] idx;
    idx = {sel[1:0], odd};
    if (sel >= lcc_pkg::CTL_SEL_ROUTE) begin
      pick_ctl = route;
    end else begin
      pick_ctl = bufs[idx];
    end
  endfunction

  // Truth tables of the eight cells.
  logic [15:0] lut_init [8];
  // Control bits written by software.
  lcc_pkg::lcc_ctrl_type ctrl;
  // Source selectors written by software.
  lcc_pkg::lcc_sel_type sel;
  // Per-cell choice of registered output.
  logic [7:0] out_reg_sel;
  // Per-cell value loaded by an active set/reset.
  logic [7:0] set_val;
  // Cell flip-flops.
  logic [7:0] q;
  // Combinational LUT results.
  logic [7:0] lut_out;
  // Carry chain nodes, entry 0 is the incoming fast carry.
  logic [8:0] carry;
  // Per-cell carry propagate condition, set when inputs one and two differ.
  logic [7:0] cell_prop;
  // First and second synchroniser stages for buffers and routing controls.
  logic [10:0] sync_a;
  logic [10:0] sync_b;
  // Selected block clock, delayed for edge detection.
  logic blk_clk;
  logic blk_clk_d;
  // One-cycle pulse at each rising edge of the block clock.
  logic tick;
  // Effective shared clock enable and set/reset.
  logic ce_eff;
  logic sr_active;
  // Configuration done seen one cycle ago.
  logic cfg_done_d;
  // Remaining cycles of post-configuration global reset.
  logic [1:0] grst_cnt;
  // Global reset is in force.
  logic grst_active;
  // Decoded address of a truth table register.
  logic lut_hit;

  // Brings the global buffers and routing controls into the clock domain.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {route_sr_in, route_ce_in, route_clk_in, global_net_buffer_in};
      sync_b <= sync_a;
    end
  end

  // Selects the shared block clock from any buffer or the routing.
  always_comb begin
    if (sel.clk_sel >= lcc_pkg::CLK_SEL_ROUTE) begin
      blk_clk = sync_b[8];
    end else begin
      blk_clk = sync_b[sel.clk_sel[2:0]];
    end
  end

  // Remembers the block clock level to find its rising edge.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      blk_clk_d <= 1'b0;
    end else begin
      blk_clk_d <= blk_clk;
    end
  end

  // A rising block clock edge becomes a one-cycle update enable.
  assign tick = blk_clk & ~blk_clk_d;

  // Odd buffers feed the clock enable, even buffers the set/reset.
  // An unused enable reads as always on, an unused set/reset as never active.
  assign ce_eff = ~ctrl.ce_use | pick_ctl(sync_b[7:0], sync_b[9], sel.ce_sel, 1'b1);
  assign sr_active = ctrl.sr_use & pick_ctl(sync_b[7:0], sync_b[10], sel.sr_sel, 1'b0);

  // Tracks configuration done to start the post-configuration reset.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      cfg_done_d <= 1'b0;
    end else begin
      cfg_done_d <= ctrl.cfg_done;
    end
  end

  // Loads the global reset count when configuration completes.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      grst_cnt <= 2'h0;
    end else if (ctrl.cfg_done & ~cfg_done_d) begin
      grst_cnt <= lcc_pkg::GRST_CYCLES;
    end else if (grst_cnt != 2'h0) begin
      grst_cnt <= grst_cnt - 2'h1;
    end
  end

  // Global reset holds throughout configuration and just after it.
  assign grst_active = ~ctrl.cfg_done | (ctrl.cfg_done & ~cfg_done_d) | (grst_cnt != 2'h0);

  // Builds the eight cells with their LUTs and carry stages.
  assign carry[0] = fast_carry_in;
  for (genvar i = 0; i < 8; i++) begin : g_cell
    // Table lookup on the four cell inputs.
    assign lut_out[i] = lut_eval(lut_init[i], lut_data_in[i]);
    // Carry from inputs one and two and the previous cell.
    assign carry[i + 1] = majority(lut_data_in[i][1], lut_data_in[i][2], carry[i]);
    // Propagate flag of the cell, watched by the carry chain check.
    assign cell_prop[i] = lut_data_in[i][1] ^ lut_data_in[i][2];
    // Output is either the LUT directly or the flip-flop.
    assign cell_out_out[i] = out_reg_sel[i] ? q[i] : lut_out[i];
  end
  assign fast_carry_out = carry[8];

  // Updates the cell flip-flops with global reset first, then set/reset, then data.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in || grst_active) begin
      // Wake-up state is reset whatever set value is chosen.
      q <= lcc_pkg::RST_BYTE;
    end else if (sr_active && (ctrl.sr_async || tick)) begin
      // Asynchronous mode acts at once; synchronous waits for the clock.
      q <= set_val;
    end else if (tick && ce_eff) begin
      // Only a clock edge with the shared enable loads data.
      q <= lut_out;
    end
  end

  // Truth table writes land on word offsets zero to seven.
  assign lut_hit = (reg_addr_in[7:5] == lcc_pkg::OFS_LUT_BASE[7:5]) && (reg_addr_in[1:0] == 2'h0);

  // Stores the truth tables.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      for (int k = 0; k < 8; k++) begin
        lut_init[k] <= lcc_pkg::RST_LUT;
      end
    end else if (reg_wr_in && lut_hit) begin
      lut_init[reg_addr_in[4:2]] <= reg_wdata_in[15:0];
    end
  end

  // Stores the control, select and output select registers.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ctrl <= lcc_pkg::RST_CTRL;
      sel <= lcc_pkg::RST_SEL;
      out_reg_sel <= lcc_pkg::RST_BYTE;
      set_val <= lcc_pkg::RST_BYTE;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        lcc_pkg::OFS_CTRL: begin
          ctrl <= lcc_pkg::lcc_ctrl_type'(reg_wdata_in[3:0]);
        end
        lcc_pkg::OFS_SELECT: begin
          sel <= lcc_pkg::lcc_sel_type'(reg_wdata_in[9:0]);
        end
        lcc_pkg::OFS_OUTSEL: begin
          out_reg_sel <= reg_wdata_in[lcc_pkg::POS_OUT_REG +: 8];
          set_val <= reg_wdata_in[lcc_pkg::POS_SET_VAL +: 8];
        end
        default: begin
          // Other offsets hold no writable state.
        end
      endcase
    end
  end

  // Returns read data one cycle after the read strobe, zero elsewhere.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= lcc_pkg::RD_ZERO;
    end else if (reg_rd_in) begin
      reg_rdata_out <= lcc_pkg::RD_ZERO;
      if (lut_hit) begin
        reg_rdata_out[15:0] <= lut_init[reg_addr_in[4:2]];
      end else begin
        case (reg_addr_in)
          lcc_pkg::OFS_CTRL: begin
            reg_rdata_out[3:0] <= ctrl;
          end
          lcc_pkg::OFS_SELECT: begin
            reg_rdata_out[9:0] <= sel;
          end
          lcc_pkg::OFS_OUTSEL: begin
            reg_rdata_out[lcc_pkg::POS_OUT_REG +: 8] <= out_reg_sel;
            reg_rdata_out[lcc_pkg::POS_SET_VAL +: 8] <= set_val;
          end
          lcc_pkg::OFS_STATUS: begin
            reg_rdata_out[lcc_pkg::POS_ST_Q +: 8] <= q;
            reg_rdata_out[lcc_pkg::POS_ST_OUT +: 8] <= cell_out_out;
            reg_rdata_out[lcc_pkg::POS_ST_CARRY] <= fast_carry_out;
            reg_rdata_out[lcc_pkg::POS_ST_GRST] <= grst_active;
          end
          default: begin
            // Unmapped offsets read as zero.
          end
        endcase
      end
    end else begin
      reg_rdata_out <= lcc_pkg::RD_ZERO;
    end
  end

  // All checks run on the system clock and pause during reset.
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);

  // Configuration completing, seen as a rising done bit.
  sequence s_cfg_complete;
    !ctrl.cfg_done ##1 ctrl.cfg_done;
  endsequence

  // Global reset spanning its three cycles and then releasing.
  sequence s_grst_window;
    grst_active [*3] ##1 !grst_active;
  endsequence

  AST_GRST_RELEASE: assert property (s_cfg_complete |-> s_grst_window)
    else $error("Global reset window after configuration is wrong.");

  AST_GRST_CLEARS: assert property (grst_active |=> q == 8'h00)
    else $error("Flip-flops not cleared under global reset.");

  AST_HOLD_IDLE: assert property (!grst_active && !sr_active && !(tick && ce_eff) |=> $stable(q))
    else $error("Flip-flop changed without clock, enable or set/reset.");

  AST_CE_BLOCKS: assert property (tick && !ce_eff && !grst_active && !sr_active |=> $stable(q))
    else $error("Clock edge loaded data while enable was low.");

  AST_SR_ASYNC: assert property (!grst_active && sr_active && ctrl.sr_async |=> q == $past(set_val))
    else $error("Asynchronous set/reset did not act at once.");

  AST_SR_SYNC_WAIT: assert property (!grst_active && sr_active && !ctrl.sr_async && !tick |=> $stable(q))
    else $error("Synchronous set/reset acted without a clock edge.");

  AST_DATA_LOAD: assert property (!grst_active && !sr_active && tick && ce_eff |=> q == $past(lut_out))
    else $error("Enabled clock edge did not load the LUT results.");

  AST_CE_ODD_BUF: assert property (ctrl.ce_use && sel.ce_sel < 3'h4
                                   |-> ce_eff == sync_b[{sel.ce_sel[1:0], 1'b1}])
    else $error("Clock enable not taken from an odd global buffer.");

  // When every cell propagates, the incoming carry must ripple to the end.
  AST_CARRY_PROP: assert property (&cell_prop |-> fast_carry_out == fast_carry_in)
    else $error("Carry through a fully propagating chain differs from its input.");

  AST_OUT_SELECT: assert property (out_reg_sel == 8'hFF |-> cell_out_out == q)
    else $error("Registered output selection not honoured.");

  AST_STATUS_READ: assert property (reg_rd_in && reg_addr_in == lcc_pkg::OFS_STATUS
                                    |=> reg_rdata_out[7:0] == $past(q))
    else $error("Status read does not show the flip-flop state.");

  // A synchronous set/reset on a clock edge wins over the data load.
  AST_SR_PRIORITY: assert property (!grst_active && sr_active && tick |=> q == $past(set_val))
    else $error("Set/reset did not win over the data load on a clock edge.");

  // Set/reset taken from a buffer must come from an even-numbered one.
  AST_SR_EVEN_BUF: assert property (ctrl.sr_use && sel.sr_sel < 3'h4
                                    |-> sr_active == sync_b[{sel.sr_sel[1:0], 1'b0}])
    else $error("Set/reset not taken from an even global buffer.");

  // A routed enable follows the synchronised routing line.
  AST_CE_ROUTE: assert property (ctrl.ce_use && sel.ce_sel >= 3'h4 |-> ce_eff == sync_b[9])
    else $error("Clock enable does not follow the routing line.");

  // A routed set/reset follows the synchronised routing line.
  AST_SR_ROUTE: assert property (ctrl.sr_use && sel.sr_sel >= 3'h4 |-> sr_active == sync_b[10])
    else $error("Set/reset does not follow the routing line.");

  // An unused enable reads as always on.
  AST_CE_UNUSED: assert property (!ctrl.ce_use |-> ce_eff)
    else $error("Unused clock enable blocked the cells.");

  // An unused set/reset never acts on the cells.
  AST_SR_UNUSED: assert property (!ctrl.sr_use |-> !sr_active)
    else $error("Unused set/reset became active.");

  // Cells selected as combinational show the LUT result directly.
  AST_LUT_COMB: assert property (out_reg_sel == 8'h00 |-> cell_out_out == lut_out)
    else $error("Combinational output selection not honoured.");

  // Until configuration is done every cell flip-flop stays cleared.
  AST_CFG_CLEARED: assert property (!ctrl.cfg_done |=> q == lcc_pkg::RST_BYTE)
    else $error("Flip-flops not cleared while configuration is pending.");

  // Read data fall back to zero outside the cycle after a read.
  AST_RDATA_IDLE: assert property (!reg_rd_in |=> reg_rdata_out == lcc_pkg::RD_ZERO)
    else $error("Read data not zero outside a read answer.");

endmodule

// ===== sim/lcc_fabric_model.sv
// Routing fabric model that drives the global buffers and the routed clock, enable and set/reset.
`timescale 1ns/1ps
module lcc_fabric_model (
  input wire logic clock_in,
  output logic [7:0] global_net_buffer_out,
  output logic route_clk_out,
  output logic route_ce_out,
  output logic route_sr_out
);
  // All fabric lines start low.
  initial begin
    global_net_buffer_out = 8'h00;
    route_clk_out = 1'h0;
    route_ce_out = 1'h0;
    route_sr_out = 1'h0;
  end

  // Sets the routed set/reset or the routed enable to a level just after the next edge.
  task automatic set_route(input logic is_sr, input logic lvl);
    @(posedge clock_in);
    if (is_sr) begin
      route_sr_out <= lvl;
    end else begin
      route_ce_out <= lvl;
    end
  endtask

  // Sets one global buffer line to a level just after the next edge.
  task automatic set_buf(input int idx, input logic lvl);
    @(posedge clock_in);
    global_net_buffer_out[idx] <= lvl;
  endtask

  // Gives one block clock period on the chosen source, three cycles high and three low.
  task automatic pulse(input logic [3:0] sel);
    @(posedge clock_in);
    if (sel < 4'h8) begin
      global_net_buffer_out[sel[2:0]] <= 1'h1;
    end else begin
      route_clk_out <= 1'h1;
    end
    repeat (3) @(posedge clock_in);
    if (sel < 4'h8) begin
      global_net_buffer_out[sel[2:0]] <= 1'h0;
    end else begin
      route_clk_out <= 1'h0;
    end
    repeat (3) @(posedge clock_in);
    #1;
  endtask
endmodule

// ===== sim/lcc_logic_cell_cluster_bench.sv
// Self-checking testbench of the logic cell cluster with its fabric model.
`timescale 1ns/1ps
module lcc_logic_cell_cluster_bench;
  logic clock_in = 1'h0; // System clock.
  logic sys_rst_in = 1'h1; // Synchronous reset, high at start.
  logic [7:0] global_net_buffer_in; // Global buffers from the fabric model.
  logic route_clk_in; // Routed clock from the fabric model.
  logic route_ce_in; // Routed enable from the fabric model.
  logic route_sr_in; // Routed set/reset from the fabric model.
  logic [7:0][3:0] lut_data_in = '0; // LUT inputs of all cells.
  logic fast_carry_in = 1'h0; // Carry into the first cell.
  logic fast_carry_out; // Carry out of the last cell.
  logic [7:0] cell_out_out; // Cell outputs.
  logic [7:0] reg_addr_in = 8'h00; // Register address.
  logic [31:0] reg_wdata_in = 32'h0000_0000; // Register write data.
  logic reg_wr_in = 1'h0; // Write strobe.
  logic reg_rd_in = 1'h0; // Read strobe.
  logic [31:0] reg_rdata_out; // Read data.
  logic [31:0] rd_val; // Last word read.
  int fails = 0; // Mismatches counted.
  int n_compared = 0; // Comparisons made.
  int cycles = 0; // Cycles since start.

  // Clock of 100 ns period.
  always #50 clock_in = ~clock_in;

  lcc_logic_cell_cluster u_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .global_net_buffer_in(global_net_buffer_in), .route_clk_in(route_clk_in), .route_ce_in(route_ce_in),
    .route_sr_in(route_sr_in), .lut_data_in(lut_data_in), .fast_carry_in(fast_carry_in),
    .fast_carry_out(fast_carry_out), .cell_out_out(cell_out_out), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out));

  lcc_fabric_model u_fab (.clock_in(clock_in), .global_net_buffer_out(global_net_buffer_in),
    .route_clk_out(route_clk_in), .route_ce_out(route_ce_in), .route_sr_out(route_sr_in));

  // Prints the counts and the verdict, then stops the run.
  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Cuts a hung run short; the tests need well under 1000 cycles.
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      finish_test;
    end
  end

  // Compares a seen value with the expected one.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One write cycle.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_wr_in <= 1'h1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_wr_in <= 1'h0;
  endtask

  // One read cycle; the data stand in the following cycle only.
  task automatic rd(input logic [7:0] a);
    @(posedge clock_in);
    reg_rd_in <= 1'h1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_rd_in <= 1'h0;
    #1;
    rd_val = reg_rdata_out;
  endtask

  // Drives the LUT inputs, each cell its own index or all the same value, and the carry in.
  task automatic apply(input logic by_idx, input logic [3:0] v, input logic cin);
    @(posedge clock_in);
    for (int i = 0; i < 8; i++) lut_data_in[i] <= by_idx ? 4'(i) : v;
    fast_carry_in <= cin;
    #1;
  endtask

  // Registers after reset, global reset pending, unmapped read.
  task automatic t_reset;
    rd(lcc_pkg::OFS_CTRL);
    check("ctrl", rd_val, 32'h0000_0000);
    rd(lcc_pkg::OFS_STATUS);
    check("status", rd_val, 32'h0002_0000);
    rd(8'h30);
    check("unmapped", rd_val, 32'h0000_0000);
  endtask

  // Configuration done starts the short global reset, which then ends.
  task automatic t_config;
    wr(lcc_pkg::OFS_CTRL, 32'h0000_0001);
    rd(lcc_pkg::OFS_STATUS);
    check("grst_on", rd_val, 32'h0002_0000);
    repeat (4) @(posedge clock_in);
    rd(lcc_pkg::OFS_STATUS);
    check("grst_off", rd_val, 32'h0000_0000);
  endtask

  // Each cell decodes one input value from its table.
  task automatic t_lut;
    for (int i = 0; i < 8; i++) wr(8'(4 * i), 32'(16'h0001 << i));
    rd(8'h0C);
    check("lut3", rd_val, 32'h0000_0008);
    apply(1'h1, 4'h0, 1'h0);
    check("lut_idx", 32'(cell_out_out), 32'h0000_00FF);
    apply(1'h0, 4'h3, 1'h0);
    check("lut_3", 32'(cell_out_out), 32'h0000_0008);
  endtask

  // Carry passes, generates and kills along the chain.
  task automatic t_carry;
    apply(1'h0, 4'h2, 1'h0);
    check("cy_p0", 32'(fast_carry_out), 32'h0000_0000);
    apply(1'h0, 4'h2, 1'h1);
    check("cy_p1", 32'(fast_carry_out), 32'h0000_0001);
    apply(1'h0, 4'h6, 1'h0);
    check("cy_g", 32'(fast_carry_out), 32'h0000_0001);
    apply(1'h0, 4'h0, 1'h1);
    check("cy_k", 32'(fast_carry_out), 32'h0000_0000);
  endtask

  // Registered outputs load only on the routed block clock.
  task automatic t_register;
    wr(lcc_pkg::OFS_OUTSEL, 32'h0000_00FF);
    wr(lcc_pkg::OFS_SELECT, 32'h0000_0008);
    apply(1'h1, 4'h0, 1'h0);
    check("q_idle", 32'(cell_out_out), 32'h0000_0000);
    u_fab.pulse(4'h8);
    check("q_load", 32'(cell_out_out), 32'h0000_00FF);
    rd(lcc_pkg::OFS_STATUS);
    check("st_q", {16'h0000, rd_val[15:0]}, 32'h0000_FFFF);
    apply(1'h0, 4'hF, 1'h0);
    check("q_hold", 32'(cell_out_out), 32'h0000_00FF);
    u_fab.pulse(4'h8);
    check("q_zero", 32'(cell_out_out), 32'h0000_0000);
  endtask

  // Clock taken from a global buffer; the routed clock is then ignored.
  task automatic t_gclk;
    wr(lcc_pkg::OFS_SELECT, 32'h0000_0003);
    apply(1'h1, 4'h0, 1'h0);
    u_fab.pulse(4'h8);
    check("gclk_no", 32'(cell_out_out), 32'h0000_0000);
    u_fab.pulse(4'h3);
    check("gclk_yes", 32'(cell_out_out), 32'h0000_00FF);
  endtask

  // Shared enable from odd buffer three; even buffer two is no enable.
  task automatic t_enable;
    wr(lcc_pkg::OFS_SELECT, 32'h0000_0018);
    wr(lcc_pkg::OFS_CTRL, 32'h0000_0005);
    u_fab.set_buf(2, 1'h1);
    apply(1'h0, 4'hF, 1'h0);
    u_fab.pulse(4'h8);
    check("ce_off", 32'(cell_out_out), 32'h0000_00FF);
    u_fab.set_buf(3, 1'h1);
    u_fab.pulse(4'h8);
    check("ce_on", 32'(cell_out_out), 32'h0000_0000);
  endtask

  // Set/reset from even buffer four, synchronous then asynchronous.
  task automatic t_setreset;
    u_fab.set_buf(5, 1'h1);
    wr(lcc_pkg::OFS_OUTSEL, 32'h0000_F0FF);
    wr(lcc_pkg::OFS_SELECT, 32'h0000_0108);
    wr(lcc_pkg::OFS_CTRL, 32'h0000_0009);
    u_fab.set_buf(4, 1'h1);
    repeat (8) @(posedge clock_in);
    #1;
    check("sr_wait", 32'(cell_out_out), 32'h0000_0000);
    u_fab.pulse(4'h8);
    check("sr_sync", 32'(cell_out_out), 32'h0000_00F0);
    u_fab.set_buf(4, 1'h0);
    u_fab.pulse(4'h8);
    check("sr_free", 32'(cell_out_out), 32'h0000_0000);
    wr(lcc_pkg::OFS_CTRL, 32'h0000_000B);
    u_fab.set_buf(4, 1'h1);
    repeat (6) @(posedge clock_in);
    #1;
    check("sr_async", 32'(cell_out_out), 32'h0000_00F0);
  endtask

  // Enable and set/reset from the routing, then a fresh configuration clears the cells.
  task automatic t_route;
    wr(lcc_pkg::OFS_SELECT, 32'h0000_0248);
    wr(lcc_pkg::OFS_CTRL, 32'h0000_000F);
    apply(1'h1, 4'h0, 1'h0);
    u_fab.pulse(4'h8);
    check("rce_off", 32'(cell_out_out), 32'h0000_00F0);
    u_fab.set_route(1'h0, 1'h1);
    u_fab.pulse(4'h8);
    check("rce_on", 32'(cell_out_out), 32'h0000_00FF);
    u_fab.set_route(1'h1, 1'h1);
    repeat (4) @(posedge clock_in);
    #1;
    check("rsr_async", 32'(cell_out_out), 32'h0000_00F0);
    wr(lcc_pkg::OFS_CTRL, 32'h0000_000E);
    rd(lcc_pkg::OFS_STATUS);
    check("rewake", rd_val, 32'h0003_0000);
  endtask

  // Main sequence: reset for six cycles, then every scenario in turn.
  initial begin
    repeat (6) @(posedge clock_in);
    sys_rst_in <= 1'h0;
    t_reset;
    t_config;
    t_lut;
    t_carry;
    t_register;
    t_gclk;
    t_enable;
    t_setreset;
    t_route;
    finish_test;
  end
endmodule
